// ### sdlpc_pkg.sv
// Shared constants and types of the serial converter load and power control
// Contract
// R1: Commands enter a 24-bit shift register; the first six bits are ignored.
// R2: Word bits 17 and 16 are the two power mode bits.
// R3: The last 16 bits are the code, loaded on the 24th falling edge.
// R4: Sync stays low for 24 falling edges or more; update on exactly the 24th.
// R5: Sync rising before the 24th edge aborts the frame, clearing the shifter.
// R6: An aborted frame changes neither the code nor the operating mode.
// R7: Power-up clears the code, which stays zero until the first full frame.
// R8: Mode 00 normal, 01 1k to ground, 10 100k to ground, 11 high impedance.
// R9: Power-down moves the output from the amplifier to the chosen load.
// R10: The code is kept through power-down and used again back in normal mode.
// R11: Back to normal mode, output is valid after 2.5 us at 5 V, 5 us at 3 V.
// R12: The host sends each word MSB first, reversing bytes if it must.
// R13: A byte-wide host sends three bytes with sync held low across all three.
// R14: An SPI host uses polarity 0, phase 1: data valid at the falling edge.
// R15: After sync falls, each falling serial clock edge shifts in one bit.
// R16: The host holds sync high at least 33 ns between frames.
// R17: Later edges wait for a new sync fall; mode and code apply together.
package sdlpc_pkg;

   // ****************************************************************
   // Word layout
   // ****************************************************************
   localparam int WORD_BITS  = 24;
   localparam int CODE_BITS  = 16;
   localparam int MODE_BITS  = 2;
   localparam int LOAD_BITS  = CODE_BITS + MODE_BITS;
   localparam int MODE_HI    = 17;
   localparam int MODE_LO    = 16;
   localparam int CODE_HI    = 15;
   localparam int CNT_BITS   = 5;
   localparam logic [CNT_BITS-1:0] LAST_BIT = 5'h17;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [CODE_BITS-1:0] CODE_RST = 16'h0000;

   // ****************************************************************
   // Timing
   // ****************************************************************
   localparam int MCLK_PERIOD_NS = 50;
   localparam int REC_NS_5V      = 2500;
   localparam int REC_NS_3V      = 5000;
   localparam int REC_BITS       = 12;
   localparam int FIFO_DEPTH     = 16;

   // ****************************************************************
   // Modes
   // ****************************************************************
   typedef enum logic [1:0] {
      SDLPC_NORMAL  = 2'h0,
      SDLPC_PD_1K   = 2'h1,
      SDLPC_PD_100K = 2'h2,
      SDLPC_PD_HIZ  = 2'h3
   } sdlpc_mode_t;

endpackage : sdlpc_pkg

// ### sdlpc_fifo.sv
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/10ps
module sdlpc_fifo #(
   parameter int W = 18,
   parameter int D = 16
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic         in_valid,
   output      logic         in_ready,
   input  wire logic [W-1:0] in_data,
   output      logic         out_valid,
   input  wire logic         out_ready,
   output      logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0]       wp;
      logic [AW-1:0]       rp;
      logic [AW:0]         cnt;
   } sdlpc_fifo_t;

   sdlpc_fifo_t st_r;
   sdlpc_fifo_t st_nxt;
   logic        push;
   logic        pop;

   assign in_ready  = (st_r.cnt != (AW+1)'(D));
   assign out_valid = (st_r.cnt != '0);
   assign out_data  = st_r.mem[st_r.rp];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wp] = in_data;
         st_nxt.wp = (st_r.wp == AW'(D-1)) ? '0 : st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = (st_r.rp == AW'(D-1)) ? '0 : st_r.rp + 1'b1;
      end
      if (push && !pop) begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end else if (pop && !push) begin
         st_nxt.cnt = st_r.cnt - 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule : sdlpc_fifo

// ### sdlpc_top.sv
// Serial command receiver, converter register and power mode control
`timescale 1ns/10ps
module sdlpc_top
   import sdlpc_pkg::*;
#(
   parameter int REC_NS = REC_NS_5V
) (
   input  wire logic                 mclk,
   input  wire logic                 rst_b,
   input  wire logic                 sclk,
   input  wire logic                 sync_b,
   input  wire logic                 din,
   output      logic [CODE_BITS-1:0] dac_code,
   output      logic [MODE_BITS-1:0] power_mode,
   output      logic                 amp_connect,
   output      logic                 term_1k_en,
   output      logic                 term_100k_en,
   output      logic                 out_hiz,
   output      logic                 out_valid,
   output      logic                 load_stall
);

   // Least recovery time, rounded up to whole cycles
   localparam int REC_CYC = (REC_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
   localparam logic [REC_BITS-1:0] REC_LOAD = REC_BITS'(REC_CYC);

   // ****************************************************************
   // Link domain: frame state, cleared by sync high
   // ****************************************************************
   typedef struct packed {
      logic [CNT_BITS-1:0]  cnt;
      logic [WORD_BITS-2:0] sh;
      logic                 done;
   } sdlpc_frame_t;

   // Link domain: loaded word, kept across frames
   typedef struct packed {
      logic [LOAD_BITS-1:0] hold;
      logic                 tog;
   } sdlpc_hold_t;

   sdlpc_frame_t         lf_r;
   sdlpc_frame_t         lf_nxt;
   sdlpc_hold_t          lh_r;
   sdlpc_hold_t          lh_nxt;
   logic                 frame_rst_b;
   logic [WORD_BITS-1:0] word_w;
   logic                 last_edge;

   // Sync high acts at once even with the serial clock stopped
   assign frame_rst_b = rst_b & ~sync_b;                 // R5
   assign word_w      = {lf_r.sh, din};
   assign last_edge   = (lf_r.cnt == LAST_BIT) & ~lf_r.done;

   always_comb begin
      lf_nxt = lf_r;
      lh_nxt = lh_r;
      if (!lf_r.done) begin
         lf_nxt.sh  = word_w[WORD_BITS-2:0];             // R15 R1
         lf_nxt.cnt = lf_r.cnt + 1'b1;
      end
      if (last_edge) begin
         lf_nxt.done = 1'b1;                             // R17
         lf_nxt.cnt  = lf_r.cnt;
         // Top six bits are dropped here
         lh_nxt.hold = word_w[MODE_HI:0];                // R2 R3 R4 R17
         lh_nxt.tog  = ~lh_r.tog;
      end
   end

   always_ff @(negedge sclk or negedge frame_rst_b) begin
      if (!frame_rst_b) begin
         lf_r <= '0;                                     // R5
      end else begin
         lf_r <= lf_nxt;
      end
   end

   // An abort never reaches this register, so old word stays
   always_ff @(negedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         lh_r <= '0;                                     // R6
      end else begin
         lh_r <= lh_nxt;
      end
   end

   // ****************************************************************
   // System domain state
   // ****************************************************************
   typedef struct packed {
      logic                 s1;
      logic                 s2;
      logic                 s3;
      logic                 pend;
      logic [LOAD_BITS-1:0] pend_w;
      logic [CODE_BITS-1:0] code;
      sdlpc_mode_t          mode;
      logic [REC_BITS-1:0]  rec;
   } sdlpc_core_t;

   sdlpc_core_t          cs_r;
   sdlpc_core_t          cs_nxt;
   logic                 f_in_ready;
   logic                 f_out_valid;
   logic                 f_out_ready;
   logic [LOAD_BITS-1:0] f_out_data;
   logic                 apply;
   logic                 take;

   // Drain stalls while the output recovers from power-down
   assign f_out_ready = (cs_r.rec == '0);
   assign apply       = f_out_valid & f_out_ready;
   // Handshake: s3 only follows once the word is taken
   assign take        = (cs_r.s2 != cs_r.s3) & ~cs_r.pend;

   always_comb begin
      cs_nxt    = cs_r;
      cs_nxt.s1 = lh_r.tog;
      cs_nxt.s2 = cs_r.s1;
      if (cs_r.pend && f_in_ready) begin
         cs_nxt.pend = 1'b0;
      end
      if (take) begin
         // Hold is stable: next load needs 24 more serial edges
         cs_nxt.s3     = cs_r.s2;
         cs_nxt.pend   = 1'b1;
         cs_nxt.pend_w = lh_r.hold;
      end
      if (cs_r.rec != '0) begin
         cs_nxt.rec = cs_r.rec - 1'b1;
      end
      if (apply) begin
         cs_nxt.code = f_out_data[CODE_HI:0];            // R3 R17
         cs_nxt.mode = sdlpc_mode_t'(f_out_data[MODE_HI:MODE_LO]); // R2
         if (cs_r.mode != SDLPC_NORMAL &&
             f_out_data[MODE_HI:MODE_LO] == SDLPC_NORMAL) begin
            cs_nxt.rec = REC_LOAD;                       // R11
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cs_r      <= '0;
         cs_r.code <= CODE_RST;                          // R7
         cs_r.mode <= SDLPC_NORMAL;
      end else begin
         cs_r <= cs_nxt;
      end
   end

   sdlpc_fifo #(
      .W (LOAD_BITS),
      .D (FIFO_DEPTH)
   ) u_fifo (
      .mclk      (mclk),
      .rst_b     (rst_b),
      .in_valid  (cs_r.pend),
      .in_ready  (f_in_ready),
      .in_data   (cs_r.pend_w),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Code is held through power-down; every applied word loads code and mode together
   assign dac_code     = cs_r.code;                      // R10
   assign power_mode   = cs_r.mode;
   assign amp_connect  = (cs_r.mode == SDLPC_NORMAL);    // R8 R9
   assign term_1k_en   = (cs_r.mode == SDLPC_PD_1K);     // R8 R9
   assign term_100k_en = (cs_r.mode == SDLPC_PD_100K);   // R8 R9
   assign out_hiz      = (cs_r.mode == SDLPC_PD_HIZ);    // R8 R9
   assign out_valid    = amp_connect & (cs_r.rec == '0); // R11
   assign load_stall   = cs_r.pend & ~f_in_ready;

   // ****************************************************************
   // Link domain checks
   // ****************************************************************
   property p_shift_in;
      @(negedge sclk) disable iff (!frame_rst_b)
      !lf_r.done ##1 (lf_r.cnt != '0) |->
         lf_r.sh[0] == $past(din);
   endproperty
   a_shift_in: assert property (p_shift_in)              // R15
      else $error("serial bit not shifted in");

   property p_load_24;
      @(negedge sclk) disable iff (!rst_b)
      last_edge |=> (lh_r.tog != $past(lh_r.tog)) &&
                    (lh_r.hold == $past(word_w[MODE_HI:0]));
   endproperty
   a_load_24: assert property (p_load_24)                // R3
      else $error("word not loaded on last edge");

   property p_no_early;
      @(negedge sclk) disable iff (!rst_b)
      !last_edge |=> $stable(lh_r.tog) && $stable(lh_r.hold);
   endproperty
   a_no_early: assert property (p_no_early)              // R5
      else $error("load outside the last edge");

   property p_ignore_after;
      @(negedge sclk) disable iff (!frame_rst_b)
      lf_r.done ##1 (lf_r.cnt != '0) |->
         lf_r.done && $stable(lf_r.sh) && $stable(lf_r.cnt);
   endproperty
   a_ignore_after: assert property (p_ignore_after)      // R17
      else $error("edge after word not ignored");

   // Zero count marks a fresh frame, so no check spans two frames
   property p_count;
      @(negedge sclk) disable iff (!frame_rst_b)
      !lf_r.done ##1 (lf_r.cnt != '0) |->
         lf_r.cnt == $past(lf_r.cnt) + (lf_r.done ? '0 : CNT_BITS'(1));
   endproperty
   a_count: assert property (p_count)                    // R4
      else $error("bit count out of step");

   // ****************************************************************
   // System domain checks
   // ****************************************************************
   property p_only_on_apply;
      @(posedge mclk) disable iff (!rst_b)
      ($changed(cs_r.code) || $changed(cs_r.mode)) |-> $past(apply);
   endproperty
   a_only_on_apply: assert property (p_only_on_apply)    // R6
      else $error("code or mode changed without a word");

   property p_decode;
      @(posedge mclk) disable iff (!rst_b)
      1'b1 |-> ($countones({amp_connect, term_1k_en,
                            term_100k_en, out_hiz}) == 1) &&
               (term_1k_en == (power_mode == 2'h1)) &&
               (term_100k_en == (power_mode == 2'h2));
   endproperty
   a_decode: assert property (p_decode)                  // R8
      else $error("mode decode wrong");

   property p_pd_disc;
      @(posedge mclk) disable iff (!rst_b)
      (power_mode != 2'h0) |-> !amp_connect && !out_valid;
   endproperty
   a_pd_disc: assert property (p_pd_disc)                // R9
      else $error("amplifier connected in power-down");

   property p_keep_code;
      @(posedge mclk) disable iff (!rst_b)
      (power_mode != 2'h0 && !apply) |=> $stable(dac_code);
   endproperty
   a_keep_code: assert property (p_keep_code)            // R10
      else $error("code lost in power-down");

   sequence s_wake;
      apply && (cs_r.mode != SDLPC_NORMAL) &&
      (f_out_data[MODE_HI:MODE_LO] == 2'h0);
   endsequence

   sequence s_recover;
      !out_valid ##[1:1000] out_valid;
   endsequence

   property p_recover;
      @(posedge mclk) disable iff (!rst_b)
      s_wake |=> s_recover;
   endproperty
   a_recover: assert property (p_recover)                // R11
      else $error("recovery wait wrong");

   property p_rst_zero;
      @(posedge mclk)
      !rst_b |=> (dac_code == CODE_RST) && (power_mode == 2'h0);
   endproperty
   a_rst_zero: assert property (p_rst_zero)              // R7
      else $error("code not cleared by reset");

   // Sync high must clear the frame even while the serial clock stands
   property p_sync_clears;
      @(posedge mclk) disable iff (!rst_b)
      sync_b |-> (lf_r == '0);
   endproperty
   a_sync_clears: assert property (p_sync_clears)        // R5
      else $error("frame state kept while sync high");

   property p_pend_held;
      @(posedge mclk) disable iff (!rst_b)
      cs_r.pend && !f_in_ready |=> cs_r.pend && $stable(cs_r.pend_w);
   endproperty
   a_pend_held: assert property (p_pend_held)            // R3
      else $error("stalled word dropped or changed");

   property p_together;
      @(posedge mclk) disable iff (!rst_b)
      apply |=> (dac_code == $past(f_out_data[CODE_HI:0])) &&
                (power_mode == $past(f_out_data[MODE_HI:MODE_LO]));
   endproperty
   a_together: assert property (p_together)              // R17
      else $error("mode and code not applied together");

endmodule : sdlpc_top

// ### sdlpc_host.sv
// Host model that sends command words over the three-wire link
`timescale 1ns/10ps
module sdlpc_host (
   output logic sclk,
   output logic sync_b,
   output logic din
);
   initial begin
      sclk   = 1'b0;
      sync_b = 1'b1;
      din    = 1'b0;
   end

   // Edges past 24 repeat the word, so a device taking them would corrupt it
   task automatic frame(input logic [23:0] w, input int n, input bit bytes);
      #7;
      sync_b = 1'b0;
      #40;
      for (int i = 0; i < n; i++) begin
         if (bytes && i != 0 && i % 8 == 0) #200;
         sclk = 1'b1;
         din  = w[23 - (i % 24)];
         #32;
         sclk = 1'b0;
         #32;
      end
      #8;
      sync_b = 1'b1;
      // Undriven line must not keep showing the last bit
      din = ~din;
      #40;
   endtask : frame
endmodule : sdlpc_host

// ### sdlpc_tb.sv
// Self-checking bench of the serial converter load and power control
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
   import sdlpc_pkg::*;
   // ****************************************************************
   // Setup
   // ****************************************************************
   localparam int REC     = 40000;
   localparam int REC_CYC = REC / MCLK_PERIOD_NS;
   typedef struct packed {
      logic [23:0] w;
      logic        bytes;
      logic [15:0] code;
      logic [1:0]  mode;
   } sdlpc_row_t;
   logic                 mclk;
   logic                 rst_b;
   logic                 sclk;
   logic                 sync_b;
   logic                 din;
   logic [CODE_BITS-1:0] dac_code;
   logic [MODE_BITS-1:0] power_mode;
   logic                 amp_connect;
   logic                 term_1k_en;
   logic                 term_100k_en;
   logic                 out_hiz;
   logic                 out_valid;
   logic                 load_stall;
   int                   err_count;
   int                   checked;
   int                   lows;
   int                   k;
   logic [1:0]           prev;
   bit                   seen;
   sdlpc_row_t           rows [5] = '{
      '{24'hfc1234, 1'b0, 16'h1234, 2'h0},
      '{24'h01abcd, 1'b1, 16'habcd, 2'h1},
      '{24'h025555, 1'b0, 16'h5555, 2'h2},
      '{24'h035555, 1'b1, 16'h5555, 2'h3},
      '{24'h005555, 1'b0, 16'h5555, 2'h0}};

   sdlpc_host host (.sclk(sclk), .sync_b(sync_b), .din(din));
   sdlpc_top #(.REC_NS(REC)) dut (
      .mclk(mclk), .rst_b(rst_b), .sclk(sclk), .sync_b(sync_b),
      .din(din), .dac_code(dac_code), .power_mode(power_mode),
      .amp_connect(amp_connect), .term_1k_en(term_1k_en),
      .term_100k_en(term_100k_en), .out_hiz(out_hiz),
      .out_valid(out_valid), .load_stall(load_stall));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic stop_test();
      $display("checked %0d err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test

   task automatic chk_out(input logic [15:0] code, input logic [1:0] mode);
      `CHK("dac_code", code, dac_code)
      `CHK("power_mode", mode, power_mode)
      `CHK("amp_connect", mode == 2'h0, amp_connect)
      `CHK("term_1k_en", mode == 2'h1, term_1k_en)
      `CHK("term_100k_en", mode == 2'h2, term_100k_en)
      `CHK("out_hiz", mode == 2'h3, out_hiz)
   endtask : chk_out

   // Applying may wait behind the queue and recovery, so bound generously
   task automatic wait_apply(input logic [15:0] code, input logic [1:0] mode);
      for (k = 0; k < 2000; k++) begin
         if (dac_code === code && power_mode === mode) break;
         @(negedge mclk);
      end
      if (k == 2000) begin
         err_count++;
         $display("[ERR] apply exp %h %h got %h %h", code, mode,
                  dac_code, power_mode);
         stop_test();
      end
   endtask : wait_apply

   // ****************************************************************
   // Sequence
   // ****************************************************************
   initial begin
      rst_b     = 1'b0;
      err_count = 0;
      checked   = 0;
      repeat (8) @(negedge mclk);
      rst_b = 1'b1;
      chk_out(16'h0000, 2'h0);
      `CHK("out_valid", 1'b1, out_valid)
      prev = 2'h0;
      foreach (rows[i]) begin
         host.frame(rows[i].w, 24, rows[i].bytes);
         wait_apply(rows[i].code, rows[i].mode);
         if (prev != 2'h0 && rows[i].mode == 2'h0) begin
            lows = 0;
            for (k = 0; k < REC_CYC + 20 && out_valid !== 1'b1; k++) begin
               lows++;
               @(negedge mclk);
            end
            seen = (lows >= REC_CYC - 1) && (lows <= REC_CYC);
            `CHK("recovery", 1'b1, seen)
         end
         chk_out(rows[i].code, rows[i].mode);
         prev = rows[i].mode;
      end
      // Sync raised one edge short of a full word
      host.frame(24'h03ffff, 23, 1'b0);
      repeat (40) @(negedge mclk);
      chk_out(16'h5555, 2'h0);
      host.frame(24'h004321, 24, 1'b0);
      wait_apply(16'h4321, 2'h0);
      chk_out(16'h4321, 2'h0);
      // Extra edges after the 24th
      host.frame(24'h00c3a5, 30, 1'b0);
      wait_apply(16'hc3a5, 2'h0);
      repeat (20) @(negedge mclk);
      chk_out(16'hc3a5, 2'h0);
      // Recovery stalls the queue while words keep coming
      host.frame(24'h010000, 24, 1'b0);
      wait_apply(16'h0000, 2'h1);
      host.frame(24'h000000, 24, 1'b0);
      wait_apply(16'h0000, 2'h0);
      seen = 1'b0;
      for (int j = 1; j <= 18; j++) begin
         host.frame({8'h00, 16'(j)}, 24, 1'b0);
         @(negedge mclk);
         if (load_stall === 1'b1) seen = 1'b1;
      end
      `CHK("load_stall_seen", 1'b1, seen)
      wait_apply(16'h0012, 2'h0);
      `CHK("load_stall", 1'b0, load_stall)
      // Reset in mid-run
      rst_b = 1'b0;
      repeat (2) @(negedge mclk);
      chk_out(16'h0000, 2'h0);
      rst_b = 1'b1;
      repeat (2) begin
         @(negedge mclk);
         chk_out(16'h0000, 2'h0);
         `CHK("out_valid", 1'b1, out_valid)
         `CHK("load_stall", 1'b0, load_stall)
      end
      stop_test();
   end
endmodule : tb
